// ==== rtl/cfg_seq_cfg.svh ====
// Purpose: Constants for the configuration port sequencer
// Assumes: 200 MHz reference clock, 5 ns period
// Notes:   Long counts are also top-level parameters
// How it works
// - Reset held low 200 ns or longer restarts a fresh configuration on release.
// - After done rises, count 49 configuration clocks, then enable user I/O.
// - Master waits 1200 us after reset release before its first clock edge.
// - Master drives select out; memory returns data on serial input.
// - Slave host drives select in and its MOSI onto serial input.
// - In user mode, serial input and select pins are released to user I/O.
// - Master load must finish within 95, 35 or 18 ms per speed.
`ifndef CFG_SEQ_CFG_SVH
`define CFG_SEQ_CFG_SVH

// ----------------------------------------
// Clock and timing
// ----------------------------------------
`define CFG_CLK_PERIOD_NS  5
`define CFG_RESET_MIN_NS   200
`define CFG_RESET_MIN_CYC  ((`CFG_RESET_MIN_NS + `CFG_CLK_PERIOD_NS - 1) / `CFG_CLK_PERIOD_NS)
`define CFG_CLEAR_US       1200
`define CFG_CLEAR_CYC      ((`CFG_CLEAR_US * 1000 + `CFG_CLK_PERIOD_NS - 1) / `CFG_CLK_PERIOD_NS)
`define CFG_WAKE_CLKS      49
`define CFG_TMO_LOW_MS     95
`define CFG_TMO_MED_MS     35
`define CFG_TMO_HIGH_MS    18
`define CFG_TMO_LOW_CYC    ((`CFG_TMO_LOW_MS * 1000000) / `CFG_CLK_PERIOD_NS)
`define CFG_TMO_MED_CYC    ((`CFG_TMO_MED_MS * 1000000) / `CFG_CLK_PERIOD_NS)
`define CFG_TMO_HIGH_CYC   ((`CFG_TMO_HIGH_MS * 1000000) / `CFG_CLK_PERIOD_NS)

// ----------------------------------------
// Master clock half periods, in reference cycles
// ----------------------------------------
`define CFG_HALF_LOW       4'h8
`define CFG_HALF_MED       4'h3
`define CFG_HALF_HIGH      4'h2

// ----------------------------------------
// Speed select codes
// ----------------------------------------
`define CFG_SPEED_LOW      2'h0
`define CFG_SPEED_MED      2'h1
`define CFG_SPEED_HIGH     2'h2

// ----------------------------------------
// Default bitstream length
// ----------------------------------------
`define CFG_BITS_DEFAULT   1024

`endif

// ==== rtl/cfg_seq_pkg.sv ====
// Purpose: Types for the configuration port sequencer
// Assumes: Constants come from cfg_seq_cfg.svh
// Notes:   One-hot state codes
package cfg_seq_pkg;

  // ----------------------------------------
  // Sequencer states
  // ----------------------------------------
  typedef enum logic [5:0] {
    ST_HOLD  = 6'h01,
    ST_CLEAR = 6'h02,
    ST_LOAD  = 6'h04,
    ST_WAKE  = 6'h08,
    ST_USER  = 6'h10,
    ST_FAIL  = 6'h20
  } seq_state_e;

  typedef logic [1:0] speed_t;

endpackage : cfg_seq_pkg

// ==== rtl/cfg_link_if.sv ====
// Purpose: Synchronised pin levels and events from sampler to sequencer
// Assumes: All signals on ref_clk_i
// Notes:   Levels are two-flop synchronised
`timescale 1ns/1ps
interface cfg_link_if;
  logic       creset_n_s;  // Synced config reset, active low
  logic       sck_rise;    // Slave write clock rising edge pulse
  logic       si_s;        // Synced serial input
  logic       sel_n_s;     // Synced select, active low
  logic       master_s;    // Synced mode strap
  logic [1:0] speed_s;     // Synced master speed select

  modport src (output creset_n_s, sck_rise, si_s, sel_n_s, master_s, speed_s);
  modport dst (input  creset_n_s, sck_rise, si_s, sel_n_s, master_s, speed_s);
endinterface : cfg_link_if

// ==== rtl/pin_sampler.sv ====
// Purpose: Two-flop synchronisers and slave clock edge finder
// Assumes: Pins are asynchronous to ref_clk_i
// Notes:   Edge detect reads only stages two and three
`timescale 1ns/1ps
module pin_sampler (
  // Clock and reset
  input  wire logic       ref_clk_i,
  input  wire logic       rstn_i,
  // Pins
  input  wire logic       config_reset_n_i,
  input  wire logic       slave_write_clock_i,
  input  wire logic       si_i,
  input  wire logic       sel_n_i,
  input  wire logic       master_mode_i,
  input  wire logic [1:0] speed_i,
  // To sequencer
  cfg_link_if.src         lk
);

  typedef struct packed {
    logic [6:0] s1;
    logic [6:0] s2;
    logic       sck3;
  } smp_s;

  smp_s q;
  smp_s d;

  // Bit order: rst, sck, si, sel, mode, speed[1:0]
  always_comb begin
    d      = q;
    d.s1   = {config_reset_n_i, slave_write_clock_i, si_i, sel_n_i, master_mode_i, speed_i};
    d.s2   = q.s1;
    d.sck3 = q.s2[5];
  end

  // Reset to idle levels so no false edge follows reset
  always_ff @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      q <= '{s1: 7'h48, s2: 7'h48, sck3: 1'b0};
    end else begin
      q <= d;
    end
  end

  // Levels straight from second stage; edge pulse also reads stage three
  assign lk.creset_n_s = q.s2[6];
  assign lk.sck_rise   = q.s2[5] & ~q.sck3;
  assign lk.si_s       = q.s2[4];
  assign lk.sel_n_s    = q.s2[3];
  assign lk.master_s   = q.s2[2];
  assign lk.speed_s    = q.s2[1:0];

endmodule : pin_sampler

// ==== rtl/cfg_seq.sv ====
// Purpose: Configuration port sequencer, master and slave load
// Assumes: ref_clk_i 200 MHz; pins asynchronous
// Notes:   Bitstream bits stream out; no storage here
`timescale 1ns/1ps
`include "cfg_seq_cfg.svh"
module cfg_seq import cfg_seq_pkg::*; #(
  parameter int unsigned BITS     = `CFG_BITS_DEFAULT,
  parameter int unsigned CLEAR_CY = `CFG_CLEAR_CYC,
  parameter int unsigned TMO_LOW  = `CFG_TMO_LOW_CYC,
  parameter int unsigned TMO_MED  = `CFG_TMO_MED_CYC,
  parameter int unsigned TMO_HIGH = `CFG_TMO_HIGH_CYC
) (
  // Clock and reset
  input  wire logic       ref_clk_i,
  input  wire logic       rstn_i,
  // Configuration pins
  input  wire logic       config_reset_n_i,
  input  wire logic       slave_write_clock_i,
  input  wire logic       si_i,
  input  wire logic       sel_n_i,
  output logic            sel_n_o,
  output logic            sel_oe_o,
  output logic            mclk_o,
  output logic            mclk_oe_o,
  // Straps
  input  wire logic       master_mode_i,
  input  wire logic [1:0] speed_i,
  // Status
  output logic            config_done_flag_o,
  output logic            user_io_en_o,
  output logic            fail_o,
  // Bitstream stream
  output logic            cfg_bit_o,
  output logic            cfg_bit_valid_o
);

  // ----------------------------------------
  // Decoders
  // ----------------------------------------
  function automatic logic [3:0] half_of(input speed_t s);
    case (s)
      `CFG_SPEED_MED:  half_of = `CFG_HALF_MED;
      `CFG_SPEED_HIGH: half_of = `CFG_HALF_HIGH;
      default:         half_of = `CFG_HALF_LOW;
    endcase
  endfunction : half_of

  function automatic logic [31:0] tmo_of(input speed_t s);
    case (s)
      `CFG_SPEED_MED:  tmo_of = 32'(TMO_MED);
      `CFG_SPEED_HIGH: tmo_of = 32'(TMO_HIGH);
      default:         tmo_of = 32'(TMO_LOW);
    endcase
  endfunction : tmo_of

  // Master owns select and clock only while loading or waking
  function automatic logic drives_pins(input logic m, input seq_state_e s);
    drives_pins = m && (s == ST_LOAD || s == ST_WAKE);
  endfunction : drives_pins

  // ----------------------------------------
  // Sampling
  // ----------------------------------------
  cfg_link_if lk ();

  pin_sampler u_smp (
    .ref_clk_i           (ref_clk_i),
    .rstn_i              (rstn_i),
    .config_reset_n_i    (config_reset_n_i),
    .slave_write_clock_i (slave_write_clock_i),
    .si_i                (si_i),
    .sel_n_i             (sel_n_i),
    .master_mode_i       (master_mode_i),
    .speed_i             (speed_i),
    .lk                  (lk.src)
  );

  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    seq_state_e  state;
    logic [7:0]  rlow;    // Reset low length
    logic [31:0] cnt;     // Clear, timeout or wake count
    logic [31:0] bits;    // Bits received
    logic        master;
    speed_t      speed;
    logic [3:0]  div;
    logic        mclk;
    logic        done;
    logic        user;
    logic        fail;
    logic        bit_q;
    logic        bit_vld;
  } seq_s;

  seq_s q;
  seq_s d;
  logic mrise;
  logic take;
  logic crise;

  // Master clock edge and bit strobe
  always_comb begin
    mrise = drives_pins(q.master, q.state) &&
            (q.div == half_of(q.speed) - 4'h1) && !q.mclk;
    crise = q.master ? mrise : lk.sck_rise;
    // Sample on our own rising edge; memory holds data from prior rise
    take  = q.master ? mrise : (lk.sck_rise && !lk.sel_n_s);
  end

  // Next-state logic
  always_comb begin
    d         = q;
    d.bit_vld = 1'b0;
    // Master clock divider runs only while loading or waking
    if (drives_pins(q.master, q.state)) begin
      if (q.div == half_of(q.speed) - 4'h1) begin
        d.div  = 4'h0;
        d.mclk = ~q.mclk;
      end else begin
        d.div = q.div + 4'h1;
      end
    end
    case (q.state)
      ST_HOLD: begin
        if (lk.creset_n_s) begin
          d.state  = ST_CLEAR;
          d.cnt    = 32'h0;
          d.master = lk.master_s;
          d.speed  = lk.speed_s;
        end
      end
      ST_CLEAR: begin
        // Memory clear; no clock out and no bit taken here
        d.cnt = q.cnt + 32'h1;
        if (q.cnt >= 32'(CLEAR_CY) - 32'h1) begin
          d.state = ST_LOAD;
          d.cnt   = 32'h0;
          d.bits  = 32'h0;
          d.div   = 4'h0;
          d.mclk  = 1'b0;
        end
      end
      ST_LOAD: begin
        d.cnt = q.cnt + 32'h1;
        if (take) begin
          d.bit_q   = lk.si_s;
          d.bit_vld = 1'b1;
          d.bits    = q.bits + 32'h1;
          if (q.bits == 32'(BITS) - 32'h1) begin
            d.state = ST_WAKE;
            d.done  = 1'b1;
            d.cnt   = 32'h0;
          end
        end
        if (q.master && q.cnt >= tmo_of(q.speed) - 32'h1 && !(take && q.bits == 32'(BITS) - 32'h1)) begin
          d.state = ST_FAIL;
        end
      end
      ST_WAKE: begin
        if (crise) begin
          d.cnt = q.cnt + 32'h1;
          if (q.cnt == 32'(`CFG_WAKE_CLKS) - 32'h1) begin
            // 49th rise shows on mclk_o in the cycle its enable drops; parking waits for user mode
            d.state = ST_USER;
            d.user  = 1'b1;
          end
        end
      end
      ST_USER: begin
        // Clock parks low once the pins are handed over
        d.mclk = 1'b0;
      end
      ST_FAIL: d.fail  = 1'b1;
      default: d.state = ST_HOLD;
    endcase
    // Restart only after a low long enough; short glitches ignored
    if (!lk.creset_n_s) begin
      if (q.rlow != 8'(`CFG_RESET_MIN_CYC)) begin
        d.rlow = q.rlow + 8'h1;
      end
    end else begin
      d.rlow = 8'h0;
    end
    if (q.rlow == 8'(`CFG_RESET_MIN_CYC)) begin
      d.state = ST_HOLD;
      d.done  = 1'b0;
      d.user  = 1'b0;
      d.fail  = 1'b0;
      d.mclk  = 1'b0;
      d.div   = 4'h0;
    end
  end

  // State register
  always_ff @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      q <= '{state: ST_HOLD, rlow: 8'h0, cnt: 32'h0, bits: 32'h0, master: 1'b0,
             speed: `CFG_SPEED_LOW, div: 4'h0, mclk: 1'b0, done: 1'b0, user: 1'b0,
             fail: 1'b0, bit_q: 1'b0, bit_vld: 1'b0};
    end else begin
      q <= d;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  // Select driven low by master only while loading or waking, then released
  assign sel_n_o   = 1'b0;
  // Enables drop in the same cycle that user mode starts
  assign sel_oe_o  = drives_pins(q.master, q.state);
  assign mclk_o    = q.mclk;
  assign mclk_oe_o = drives_pins(q.master, q.state);
  assign config_done_flag_o = q.done;
  assign user_io_en_o       = q.user;
  assign fail_o             = q.fail;
  assign cfg_bit_o          = q.bit_q;
  assign cfg_bit_valid_o    = q.bit_vld;

endmodule : cfg_seq

// ==== verification/cfg_seq_chk.sv ====
// Purpose: Port checks for the configuration sequencer
// Assumes: One clock domain, synchronous reset
// Notes:   Bound into every cfg_seq
`timescale 1ns/1ps
module cfg_seq_chk #(
  parameter int unsigned CLEAR_CY = 50
) (
  input wire logic ref_clk_i,
  input wire logic rstn_i,
  input wire logic config_reset_n_i,
  input wire logic master_mode_i,
  input wire logic sel_n_o,
  input wire logic sel_oe_o,
  input wire logic mclk_o,
  input wire logic mclk_oe_o,
  input wire logic config_done_flag_o,
  input wire logic user_io_en_o,
  input wire logic fail_o,
  input wire logic cfg_bit_valid_o
);
  int unsigned lo_q;
  int unsigned hi_q;
  // Lengths of the reset pin low and high spells
  always_ff @(posedge ref_clk_i) begin
    lo_q <= config_reset_n_i ? 0 : (lo_q < 99 ? lo_q + 1 : lo_q);
    hi_q <= (!rstn_i || !config_reset_n_i) ? 0 : hi_q + 1;
  end
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!rstn_i);
  a_user_needs_done : assert property (user_io_en_o |-> config_done_flag_o)
    else $error("user io without done");
  a_wake_not_early : assert property ($rose(config_done_flag_o) |-> !user_io_en_o [*8])
    else $error("user io too soon");
  a_sel_drive_low : assert property (sel_oe_o |-> !sel_n_o)
    else $error("select driven high");
  a_master_pair : assert property (mclk_oe_o |-> sel_oe_o && master_mode_i)
    else $error("clock without select");
  a_pins_released : assert property (user_io_en_o |-> !sel_oe_o && !mclk_oe_o)
    else $error("pins held in user mode");
  a_bit_pulse : assert property (cfg_bit_valid_o |=> !cfg_bit_valid_o)
    else $error("bit valid too long");
  a_fail_no_done : assert property (fail_o |-> !config_done_flag_o)
    else $error("done with failure");
  a_restart_clear : assert property (lo_q >= 48 |-> !config_done_flag_o && !user_io_en_o && !fail_o)
    else $error("restart left status");
  a_done_fall : assert property ($fell(config_done_flag_o) |-> lo_q >= 40)
    else $error("done dropped early");
  a_clear_wait : assert property ($rose(mclk_o) |-> hi_q >= CLEAR_CY)
    else $error("master clock too soon");
  c_done : cover property ($rose(config_done_flag_o));
  c_user : cover property ($rose(user_io_en_o));
  c_fail : cover property ($rose(fail_o));
endmodule : cfg_seq_chk

bind cfg_seq cfg_seq_chk #(.CLEAR_CY(CLEAR_CY)) chk (.ref_clk_i, .rstn_i, .config_reset_n_i, .master_mode_i,
  .sel_n_o, .sel_oe_o, .mclk_o, .mclk_oe_o, .config_done_flag_o, .user_io_en_o, .fail_o,
  .cfg_bit_valid_o);

// ==== verification/flash_model.sv ====
// Purpose: Serial memory holding a bitstream image
// Assumes: Next bit follows each rising master clock
// Notes:   Released line shows the inverse of its last level
`timescale 1ns/1ps
module flash_model #(
  parameter logic [15:0] IMG = 16'hC35A
) (
  input  wire logic mclk_i,
  input  wire logic sel_n_i,
  input  wire logic slow_i,
  output logic      si_o
);
  int idx = 0;
  initial si_o = 1'b0;
  // First bit on select, stale level never kept
  always @(sel_n_i) begin
    idx = 0;
    si_o <= sel_n_i ? ~si_o : IMG[15];
  end
  // Slow answer lands 7 ns late
  always @(posedge mclk_i) if (!sel_n_i) begin
    idx = idx + 1;
    si_o <= #(slow_i ? 7 : 0) IMG[15 - idx % 16];
  end
endmodule : flash_model

// ==== verification/cfg_seq_tb.sv ====
// Purpose: Self-checking bench for the configuration sequencer
// Assumes: 200 MHz reference, 48 ns slave write clock
// Notes:   Long counts shortened through parameters
`timescale 1ns/1ps
module cfg_seq_tb;
  localparam int unsigned CLEAR = 50;
  localparam logic [15:0] IMG = 16'hC35A;
  localparam logic [15:0] PAT = 16'h9E61;
  logic ref_clk = 0, rstn = 0, cr_n = 1, sck = 0, hsi = 0, hsel = 1, master = 0, slow = 0;
  logic [1:0] speed = 2'h0;
  logic [15:0] cap = 16'h0000;
  logic sel_o, sel_oe, mclk, mclk_oe, done, user, fail, sbit, vld, fsi, sel_w, si_w;
  int checked = 0, mismatches = 0;
  // Shared select and data wires
  assign sel_w = sel_oe ? sel_o : hsel;
  assign si_w = master ? fsi : hsi;
  cfg_seq #(.BITS(16), .CLEAR_CY(CLEAR), .TMO_LOW(5000), .TMO_MED(5000), .TMO_HIGH(40)) dut (
    .ref_clk_i(ref_clk), .rstn_i(rstn), .config_reset_n_i(cr_n), .slave_write_clock_i(sck),
    .si_i(si_w), .sel_n_i(sel_w), .sel_n_o(sel_o), .sel_oe_o(sel_oe), .mclk_o(mclk),
    .mclk_oe_o(mclk_oe), .master_mode_i(master), .speed_i(speed), .config_done_flag_o(done),
    .user_io_en_o(user), .fail_o(fail), .cfg_bit_o(sbit), .cfg_bit_valid_o(vld));
  flash_model #(.IMG(IMG)) mem (.mclk_i(mclk), .sel_n_i(sel_w), .slow_i(slow), .si_o(fsi));
  // Delivered bits, first bit ends up on top
  always @(posedge ref_clk) if (vld) cap <= {cap[14:0], sbit};
  initial forever #2.5 ref_clk = ~ref_clk;
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    checked++;
    if (g !== e) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
  endtask : cyc
  task automatic restart(input int n);
    cyc(1);
    cr_n <= 1'b0;
    cyc(n);
    cr_n <= 1'b1;
  endtask : restart
  // About 21 MHz, free of the reference phase
  task automatic pulses(input int n);
    repeat (n) begin
      #24 sck <= 1'b1;
      #24 sck <= 1'b0;
    end
  endtask : pulses
  task automatic sbits(input logic [15:0] d);
    for (int i = 15; i >= 0; i--) begin
      hsi <= d[i];
      pulses(1);
    end
    hsi <= ~d[0];
  endtask : sbits
  task automatic wait_end;
    for (int i = 0; i < 3000 && !(done | fail); i++) @(negedge ref_clk);
    @(negedge ref_clk);
  endtask : wait_end
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_master(input logic [1:0] sp);
    int n;
    logic p;
    n = 0;
    cyc(1);
    master <= 1'b1;
    speed <= sp;
    slow <= sp[0];
    restart(50);
    wait_end();
    chk("done", 16'h0001, {15'h0, done});
    chk("image", IMG, cap);
    p = mclk;
    for (int i = 0; i < 3000 && !user; i++) begin
      @(negedge ref_clk);
      if (mclk && !p) n++;
      p = mclk;
    end
    chk("wake clocks", 16'h0031, n[15:0]);
    chk("pins", 16'h0000, {14'h0, sel_oe, mclk_oe});
  endtask : t_master
  task automatic t_timeout;
    cyc(1);
    speed <= 2'h2;
    restart(50);
    wait_end();
    chk("fail", 16'h0001, {15'h0, fail});
    chk("done", 16'h0000, {15'h0, done});
  endtask : t_timeout
  task automatic t_slave;
    cyc(1);
    master <= 1'b0;
    restart(50);
    hsel <= 1'b0;
    pulses(2);
    hsel <= 1'b1;
    cyc(CLEAR);
    pulses(1);
    hsel <= 1'b0;
    sbits(PAT);
    hsel <= 1'b1;
    cyc(10);
    chk("done", 16'h0001, {15'h0, done});
    chk("slave bits", PAT, cap);
    pulses(48);
    cyc(10);
    chk("user early", 16'h0000, {15'h0, user});
    pulses(1);
    cyc(10);
    chk("user", 16'h0001, {15'h0, user});
  endtask : t_slave
  task automatic t_glitch;
    restart(30);
    cyc(60);
    chk("user kept", 16'h0001, {15'h0, user});
    restart(50);
    cyc(10);
    chk("status dropped", 16'h0000, {14'h0, done, user});
  endtask : t_glitch
  task automatic complete_run;
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : complete_run
  initial begin
    cyc(6);
    rstn <= 1'b1;
    for (int s = 0; s < 4; s++) if (s != 2) t_master(2'(s));
    t_timeout();
    t_slave();
    t_glitch();
    complete_run();
  end
  // Hang guard, well past the expected run
  initial begin
    #100us;
    mismatches++;
    complete_run();
  end
endmodule : cfg_seq_tb
